// >>> verilog/lme_pkg.sv
/*
 * Constants shared by the load/multiply/OR execution unit: register map,
 * flag bit positions, opcodes and cycle counts for each instruction.
 * Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
 */
package lme_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DST = 8'h08;
	localparam logic [7:0] ADDR_SRC = 8'h0c;
	localparam logic [7:0] ADDR_PTR = 8'h10;
	localparam logic [7:0] ADDR_IP = 8'h14;
	localparam logic [7:0] ADDR_PC = 8'h18;
	localparam logic [7:0] ADDR_FLAGS = 8'h1c;

	// CTRL fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_FIELD_LSB = 8;
	localparam int CTRL_START_BIT = 16;
	// STATUS fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_BADOP_BIT = 2;

	// Flag register bit positions
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;

	// Opcodes
	localparam logic [7:0] OP_STORE_PREDEC = 8'hf2;
	localparam logic [7:0] OP_STORE_PREINC = 8'hf3;
	localparam logic [7:0] OP_WORD_RR = 8'hc4;
	localparam logic [7:0] OP_WORD_IR = 8'hc5;
	localparam logic [7:0] OP_WORD_IM = 8'hc6;
	localparam logic [7:0] OP_MUL_R = 8'h84;
	localparam logic [7:0] OP_MUL_IR = 8'h85;
	localparam logic [7:0] OP_MUL_IM = 8'h86;
	localparam logic [7:0] OP_NEXT = 8'h0f;
	localparam logic [7:0] OP_NOP = 8'hff;
	localparam logic [7:0] OP_OR_FIRST = 8'h42;
	localparam logic [7:0] OP_OR_RR = 8'h42;
	localparam logic [7:0] OP_OR_LAST = 8'h46;

	// Execution times in clock cycles
	localparam logic [4:0] CYC_STORE = 5'h0e;
	localparam logic [4:0] CYC_WORD = 5'h08;
	localparam logic [4:0] CYC_MUL = 5'h16;
	localparam logic [4:0] CYC_NEXT = 5'h0a;
	localparam logic [4:0] CYC_NOP = 5'h04;
	localparam logic [4:0] CYC_OR_SHORT = 5'h04;
	localparam logic [4:0] CYC_OR_LONG = 5'h06;

	localparam logic [15:0] IP_STEP = 16'h0002;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	localparam logic [8:0] PRODUCT_MAX = 9'h0ff;
endpackage

// >>> verilog/lme_exec.sv
/*
 * Execution unit for pre-modified block stores, word load, unsigned
 * multiply, threaded-code dispatch, no-operation and logical OR.
 * Operands, pointer, IP, PC and flags live in registers reached over
 * AHB-Lite; block stores leave on the memory write port, the dispatch
 * reads program memory on a same-clock read port. Assumes zero-wait
 * single-word AHB-Lite transfers and a same-clock program memory read.
 */
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
// Operation
// - F2: decrement pointer, store byte, 14 cycles
// - F3: increment pointer, store byte, 14 cycles
// - Even pair field: program, odd: external
// - Store, word, dispatch, nop keep flags
// - Word load C4/C5/C6 copies source, 8 cycles
// - Even source byte into even destination
// - Unsigned 8x8 multiply 84-86, 22 cycles
// - Multiply sets C, Z, S, clears V
// - Dispatch: PC from program word, IP+2
// - NOP FF changes nothing, 4 cycles
// - OR 42-46 writes destination OR source
// - OR sets Z, S, clears V
`timescale 1ns/100ps
module lme_exec
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic mem_wr,
	output logic mem_ext,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic [15:0] pm_raddr,
	input wire logic [15:0] pm_rdata
);

	typedef struct packed {
		logic ready;
		logic [31:0] rdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [7:0] opcode;
		logic [3:0] field;
		logic busy;
		logic done;
		logic badop;
		logic [4:0] cnt;
		logic [15:0] dst;
		logic [15:0] src;
		logic [15:0] ptr;
		logic [15:0] ip;
		logic [15:0] pc;
		logic [7:0] flags;
		logic mem_wr;
		logic mem_ext;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
	} lme_state_t;

	lme_state_t st_r;
	lme_state_t st_nxt;

	// Register index for an address, shared by read and write paths
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		unique case (a)
			lme_pkg::ADDR_CTRL: reg_sel = 4'h1;
			lme_pkg::ADDR_STATUS: reg_sel = 4'h2;
			lme_pkg::ADDR_DST: reg_sel = 4'h3;
			lme_pkg::ADDR_SRC: reg_sel = 4'h4;
			lme_pkg::ADDR_PTR: reg_sel = 4'h5;
			lme_pkg::ADDR_IP: reg_sel = 4'h6;
			lme_pkg::ADDR_PC: reg_sel = 4'h7;
			lme_pkg::ADDR_FLAGS: reg_sel = 4'h8;
			default: reg_sel = 4'h0;
		endcase
	endfunction

	// Execution time of an opcode; zero marks an opcode not handled here
	function automatic logic [4:0] cycles_of(input logic [7:0] op);
		if (op == lme_pkg::OP_STORE_PREDEC || op == lme_pkg::OP_STORE_PREINC)
			cycles_of = lme_pkg::CYC_STORE;
		else if (op >= lme_pkg::OP_WORD_RR && op <= lme_pkg::OP_WORD_IM)
			cycles_of = lme_pkg::CYC_WORD;
		else if (op >= lme_pkg::OP_MUL_R && op <= lme_pkg::OP_MUL_IM)
			cycles_of = lme_pkg::CYC_MUL;
		else if (op == lme_pkg::OP_NEXT)
			cycles_of = lme_pkg::CYC_NEXT;
		else if (op == lme_pkg::OP_NOP)
			cycles_of = lme_pkg::CYC_NOP;
		else if (op == lme_pkg::OP_OR_RR)
			cycles_of = lme_pkg::CYC_OR_SHORT;
		else if (op > lme_pkg::OP_OR_FIRST && op <= lme_pkg::OP_OR_LAST)
			cycles_of = lme_pkg::CYC_OR_LONG;
		else
			cycles_of = 5'h00;
	endfunction

	logic addr_ph;
	logic [7:0] addr_lo;
	logic [15:0] product;
	logic [7:0] or_res;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_inc;
	logic [4:0] op_cycles;

	// Address phase qualification and operation datapaths
	assign addr_ph = hsel && htrans[1] && hready;
	assign addr_lo = haddr[7:0];
	assign product = st_r.dst[15:8] * st_r.src[7:0];
	assign or_res = st_r.dst[7:0] | st_r.src[7:0];
	assign ptr_dec = st_r.ptr - lme_pkg::PTR_STEP;
	assign ptr_inc = st_r.ptr + lme_pkg::PTR_STEP;
	assign op_cycles = cycles_of(hwdata[lme_pkg::CTRL_OP_LSB +: 8]);

	// Next-state logic: bus slave, register writes and execution
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ready = 1'b1;
		st_nxt.mem_wr = 1'b0;

		// Register write data phase; operands locked while busy
		if (st_r.wr_pend && !st_r.busy)
		begin
			unique case (reg_sel(st_r.wr_addr))
				4'h1:
				begin
					st_nxt.opcode = hwdata[lme_pkg::CTRL_OP_LSB +: 8];
					st_nxt.field = hwdata[lme_pkg::CTRL_FIELD_LSB +: 4];
					if (hwdata[lme_pkg::CTRL_START_BIT])
					begin
						st_nxt.done = 1'b0;
						st_nxt.badop = (op_cycles == 5'h00);
						st_nxt.busy = (op_cycles != 5'h00);
						st_nxt.cnt = op_cycles;
						st_nxt.done = (op_cycles == 5'h00);
					end
				end
				4'h3: st_nxt.dst = hwdata[15:0];
				4'h4: st_nxt.src = hwdata[15:0];
				4'h5: st_nxt.ptr = hwdata[15:0];
				4'h6: st_nxt.ip = hwdata[15:0];
				4'h7: st_nxt.pc = hwdata[15:0];
				4'h8: st_nxt.flags = hwdata[7:0];
				default: st_nxt.flags = st_r.flags;
			endcase
		end

		// Count the execution time down and commit on the last cycle
		if (st_r.busy)
		begin
			st_nxt.cnt = st_r.cnt - 5'h01;
			if (st_r.cnt == 5'h01)
			begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
				if (st_r.opcode == lme_pkg::OP_STORE_PREDEC ||
					st_r.opcode == lme_pkg::OP_STORE_PREINC)
				begin
					// Pointer is modified first, then used as the address
					if (st_r.opcode == lme_pkg::OP_STORE_PREDEC)
						st_nxt.ptr = ptr_dec;
					else
						st_nxt.ptr = ptr_inc;
					st_nxt.mem_addr = st_nxt.ptr;
					st_nxt.mem_wdata = st_r.src[7:0];
					st_nxt.mem_ext = st_r.field[0];
					st_nxt.mem_wr = 1'b1;
				end
				else if (st_r.opcode >= lme_pkg::OP_WORD_RR &&
					st_r.opcode <= lme_pkg::OP_WORD_IM)
					st_nxt.dst = st_r.src;
				else if (st_r.opcode >= lme_pkg::OP_MUL_R &&
					st_r.opcode <= lme_pkg::OP_MUL_IM)
				begin
					st_nxt.dst = product;
					st_nxt.flags[lme_pkg::FLAG_C] =
						({1'b0, product[15:8]} != 9'h000) &&
						(product > {7'h00, lme_pkg::PRODUCT_MAX});
					st_nxt.flags[lme_pkg::FLAG_Z] = (product == 16'h0000);
					st_nxt.flags[lme_pkg::FLAG_S] = product[15];
					st_nxt.flags[lme_pkg::FLAG_V] = 1'b0;
				end
				else if (st_r.opcode == lme_pkg::OP_NEXT)
				begin
					st_nxt.pc = pm_rdata;
					st_nxt.ip = st_r.ip + lme_pkg::IP_STEP;
				end
				else if (st_r.opcode >= lme_pkg::OP_OR_FIRST &&
					st_r.opcode <= lme_pkg::OP_OR_LAST)
				begin
					st_nxt.dst[7:0] = or_res;
					st_nxt.flags[lme_pkg::FLAG_Z] = (or_res == 8'h00);
					st_nxt.flags[lme_pkg::FLAG_S] = or_res[7];
					st_nxt.flags[lme_pkg::FLAG_V] = 1'b0;
				end
				else
					st_nxt.flags = st_r.flags;
			end
		end

		// Address phase: remember writes, prepare read data
		st_nxt.wr_pend = addr_ph && hwrite;
		st_nxt.wr_addr = addr_lo;
		if (addr_ph && !hwrite)
		begin
			unique case (reg_sel(addr_lo))
				4'h1: st_nxt.rdata = {15'h0000, 1'b0, 4'h0,
					st_r.field, st_r.opcode};
				4'h2: st_nxt.rdata = {19'h00000, 3'h0, st_r.cnt,
					2'h0, st_r.badop, st_r.done, st_r.busy};
				4'h3: st_nxt.rdata = {16'h0000, st_r.dst};
				4'h4: st_nxt.rdata = {16'h0000, st_r.src};
				4'h5: st_nxt.rdata = {16'h0000, st_r.ptr};
				4'h6: st_nxt.rdata = {16'h0000, st_r.ip};
				4'h7: st_nxt.rdata = {16'h0000, st_r.pc};
				4'h8: st_nxt.rdata = {24'h000000, st_r.flags};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			st_r <= '0;
			st_r.ready <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state flops
	assign hreadyout = st_r.ready;
	assign hrdata = st_r.rdata;
	assign mem_wr = st_r.mem_wr;
	assign mem_ext = st_r.mem_ext;
	assign mem_addr = st_r.mem_addr;
	assign mem_wdata = st_r.mem_wdata;
	assign pm_raddr = st_r.ip; // Held at IP while a dispatch runs

	// Response is always OKAY
	logic resp_r;
	always_ff @(posedge mclk)
	begin
		resp_r <= 1'b0;
	end
	assign hresp = resp_r;

endmodule // lme_exec

// >>> bench/lme_pmem.sv
/* Program memory model for the dispatch read port.
 * Assumes a same-clock read: the word follows the address at once. */
`timescale 1ns/100ps
module lme_pmem
(
	input wire logic [15:0] pm_raddr,
	output logic [15:0] pm_rdata
);
	// Word content is the address with its bytes swapped, XOR 00a5, so each word differs
	assign pm_rdata = {pm_raddr[7:0], pm_raddr[15:8]} ^ 16'h00a5;
endmodule // lme_pmem

// >>> bench/lme_exec_sva.sv
/* Checker for bus answers and store port timing of lme_exec.
 * Bound to lme_exec; sees its ports only. */
`timescale 1ns/100ps
module lme_chk
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic mem_wr,
	input wire logic mem_ext,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [15:0] pm_raddr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Read of an unmapped place: address phase, then data phase
	sequence s_rd_gap;
		hsel && htrans[1] && !hwrite && hready && haddr[7:0] >= 8'h20
		##1 hready;
	endsequence
	AST_READY: assert property (hreadyout)
		else $error("wait state inserted");
	AST_OKAY: assert property (!hresp)
		else $error("error response");
	AST_PULSE: assert property ($rose(mem_wr) |=> !mem_wr [*8])
		else $error("store strobe too long or too close");
	AST_STORE: assert property (mem_wr |-> $past(hwdata[16], 15)
		&& $past(hwdata[7:1], 15) == 7'h79
		&& mem_ext == $past(hwdata[8], 15))
		else $error("store not 14 cycles after its start");
	AST_UNMAPPED: assert property (s_rd_gap |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_IP_STEP: assert property ($past(rstn) && $changed(pm_raddr)
		|-> pm_raddr == $past(pm_raddr) + 16'h0002
		|| pm_raddr == $past(hwdata[15:0]))
		else $error("instruction pointer moved wrongly");
	AST_ADDR_HOLD: assert property ($past(rstn) && !mem_wr
		|-> $stable(mem_addr) && $stable(mem_wdata))
		else $error("store port moved without a store");
	AST_RDATA_HOLD: assert property (!(hsel && htrans[1] && !hwrite)
		|=> $stable(hrdata))
		else $error("read data changed without a read");
endmodule // lme_chk
bind lme_exec lme_chk lme_chk_i (.mclk(mclk), .rstn(rstn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.mem_wr(mem_wr), .mem_ext(mem_ext), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .pm_raddr(pm_raddr));

// >>> bench/test_lme_exec.sv
/* Bench for lme_exec: AHB-Lite master and one task per instruction group, OR with word and dispatch with nop.
 * Assumes lme_pmem answers the dispatch read. */
`timescale 1ns/100ps
module test_lme_exec;
	logic mclk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic hreadyout, hresp, mem_wr, mem_ext;
	logic [15:0] mem_addr, pm_raddr, pm_rdata;
	logic [7:0] mem_wdata;
	int fails = 0, n_checks = 0;
	// Free-running 100 MHz clock
	always #5 mclk = ~mclk;
	lme_exec lme_exec_i (.mclk(mclk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .mem_wr(mem_wr), .mem_ext(mem_ext),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .pm_raddr(pm_raddr),
		.pm_rdata(pm_rdata));
	lme_pmem lme_pmem_i (.pm_raddr(pm_raddr), .pm_rdata(pm_rdata));
	task automatic wrap_up();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask
	// Next edge with hready high, bounded
	task automatic edge_rdy();
		int k;
		k = 0;
		@(posedge mclk);
		while (hreadyout !== 1'h1 && k < 50)
		begin
			@(posedge mclk);
			k++;
		end
		if (hreadyout !== 1'h1)
		begin
			fails++;
			wrap_up();
		end
	endtask
	// One single word transfer; read data lands in rv
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		rv = hrdata;
	endtask
	task automatic rck(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(1'h0, a, 32'h0);
		chk(nm, rv, e);
	endtask
	// Start an opcode, then poll status until idle and done
	task automatic run(input logic [7:0] op, input logic [3:0] fld);
		int k;
		xfer(1'h1, 8'h00, {15'h0, 1'h1, 4'h0, fld, op});
		k = 0;
		rv = 32'h0;
		while (rv[1:0] !== 2'h2 && k < 60)
		begin
			xfer(1'h0, 8'h04, 32'h0);
			k++;
		end
		if (rv[1:0] !== 2'h2)
		begin
			fails++;
			wrap_up();
		end
	endtask
	// PC write refused while busy, then an opcode outside this group
	task automatic sc_busy_bad();
		xfer(1'h1, 8'h00, {15'h0, 1'h1, 4'h0, 4'h0, 8'hff});
		xfer(1'h1, 8'h18, 32'h1234);
		rck(8'h18, 32'h00a4, "refused pc");
		run(8'h50, 4'h0);
		rck(8'h04, 32'h6, "bad op status");
		rck(8'h1c, 32'ha0, "bad op flags");
	endtask
	task automatic sc_store(input logic [7:0] op, input logic [3:0] f, input logic [15:0] p0, p1);
		xfer(1'h1, 8'h10, {16'h0, p0});
		xfer(1'h1, 8'h0c, 32'h77);
		xfer(1'h1, 8'h1c, 32'h3f);
		run(op, f);
		rck(8'h10, {16'h0, p1}, "ptr");
		rck(8'h1c, 32'h3f, "flags");
		chk("addr", {16'h0, mem_addr}, {16'h0, p1});
		chk("ext", {31'h0, mem_ext}, {31'h0, f[0]});
		chk("byte", {24'h0, mem_wdata}, 32'h77);
	endtask
	task automatic sc_mul(input logic [7:0] op, input logic [15:0] d, s, p, input logic [7:0] f);
		xfer(1'h1, 8'h08, {16'h0, d});
		xfer(1'h1, 8'h0c, {16'h0, s});
		xfer(1'h1, 8'h1c, 32'h1f);
		run(op, 4'h0);
		rck(8'h08, {16'h0, p}, "product");
		rck(8'h1c, {24'h0, f}, "mul flags");
	endtask
	task automatic sc_or_word();
		for (int op = 8'h42; op <= 8'h46; op++)
		begin
			xfer(1'h1, 8'h08, 32'hab15);
			xfer(1'h1, 8'h0c, 32'haa);
			xfer(1'h1, 8'h1c, 32'hd0);
			run(op[7:0], 4'h0);
			rck(8'h08, 32'habbf, "or result");
			rck(8'h1c, 32'ha0, "or flags");
		end
		for (int op = 8'hc4; op <= 8'hc6; op++)
		begin
			xfer(1'h1, 8'h08, 32'h0);
			xfer(1'h1, 8'h0c, 32'h061c);
			run(op[7:0], 4'h0);
			rck(8'h08, 32'h061c, "word");
			rck(8'h0c, 32'h061c, "word src");
			rck(8'h1c, 32'ha0, "word flags");
		end
	endtask
	task automatic sc_next_nop();
		xfer(1'h1, 8'h14, 32'h0100);
		run(8'h0f, 4'h0);
		rck(8'h18, 32'h00a4, "pc");
		rck(8'h14, 32'h0102, "ip");
		run(8'hff, 4'h0);
		rck(8'h18, 32'h00a4, "nop pc");
		rck(8'h1c, 32'ha0, "nop flags");
		rck(8'h20, 32'h0, "unmapped");
	endtask
	// Reset, then the scenarios in turn
	initial
	begin
		repeat (8) @(posedge mclk);
		rstn <= 1'h1;
		@(posedge mclk);
		sc_store(8'hf2, 4'h7, 16'h3000, 16'h2fff);
		sc_store(8'hf3, 4'h6, 16'h21ff, 16'h2200);
		sc_mul(8'h84, 16'h2003, 16'h09, 16'h0120, 8'h8f);
		sc_mul(8'h86, 16'hff00, 16'hff, 16'hfe01, 8'haf);
		sc_mul(8'h85, 16'h0033, 16'h05, 16'h0000, 8'h4f);
		sc_or_word();
		sc_next_nop();
		sc_busy_bad();
		wrap_up();
	end
endmodule // test_lme_exec
